// ---- bench/lair_regs_asserts.sv ----
// Assertion checker for the link status register bank
`timescale 1ns/10ps
`include "lair_consts.svh"
module lair_regs_asserts
    import lair_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Packet contents
    input wire lair_acr_t acr_in,
    input wire lair_avi_t avi_in
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    lair_idx_t ar_idx_q;
    lair_acr_t acr_q;
    lair_avi_t avi_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_idx_q <= '0;
            acr_q <= '0;
            avi_q <= '0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) ar_idx_q <= s_axi_araddr[11:2];
            if (acr_in.valid) acr_q <= acr_in;
            if (avi_in.valid) avi_q <= avi_in;
        end
    end
    AST_WR_RESP: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write response late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##1 s_axi_rvalid)
        else $error("read answer timing wrong");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped");
    AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read upper bytes not zero");
    AST_RD_SPLIT: assert property (
        $rose(s_axi_rvalid) && ar_idx_q == `LAIR_IDX_TS_LOW_DIV_HIGH
        |-> s_axi_rdata[7:0] == {$past(acr_q.stamp[3:0]), $past(acr_q.divider[19:16])})
        else $error("shared byte wrong");
    AST_RD_FLAGS: assert property (
        $rose(s_axi_rvalid) && ar_idx_q == `LAIR_IDX_VIF_FLAGS
        |-> s_axi_rdata[7:0] == {1'b0, $past(avi_q.enc), $past(avi_q.afi),
            $past(avi_q.bar), $past(avi_q.scan)})
        else $error("flags byte wrong");
    AST_RD_COLOUR: assert property (
        $rose(s_axi_rvalid) && ar_idx_q == `LAIR_IDX_VIF_COLOUR
        |-> s_axi_rdata[7:0] == {$past(avi_q.col), 6'h00})
        else $error("colour byte wrong");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && !s_axi_rready);
    cover property ($rose(s_axi_rvalid) && ar_idx_q == `LAIR_IDX_VIF_FLAGS);
    cover property (s_axi_rvalid && s_axi_rresp == `LAIR_RESP_SLVERR);
endmodule
bind lair_regs lair_regs_asserts chk_u (.*);

// ---- bench/lair_src_model.sv ----
// Behavioural video source driving decoded packet contents
`timescale 1ns/10ps
module lair_src_model
    import lair_pkg::*;
(
    // Commands from the bench
    input wire lair_acr_t acr_cmd,
    input wire lair_avi_t avi_cmd,
    input wire lair_aud_t aud_cmd,
    // Packet contents to the receiver
    output lair_acr_t acr_in,
    output lair_avi_t avi_in,
    output lair_aud_t aud_in
);
    // Outside a packet the fields show stale inverted data
    assign acr_in = acr_cmd.valid ? acr_cmd : {1'b0, ~acr_cmd[39:0]};
    assign avi_in = avi_cmd.valid ? avi_cmd : {1'b0, ~avi_cmd[16:0]};
    assign aud_in = aud_cmd.valid ? aud_cmd : {1'b0, ~aud_cmd[3:0]};
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench for the link status register bank
`timescale 1ns/10ps
`include "lair_consts.svh"
module testbench
    import lair_pkg::*;
();
    logic aclk = 1'b0;
    logic aresetn;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    lair_acr_t acr_cmd, acr_in, acr_e;
    lair_avi_t avi_cmd, avi_in, avi_e;
    lair_aud_t aud_cmd, aud_in, aud_e;
    int n_mismatch = 0;
    int n_tests = 0;
    lair_idx_t idx_tab [9] = '{10'h062, 10'h07B, 10'h07C, 10'h07D, 10'h07E, 10'h07F,
        10'h080, 10'h081, 10'h082};
    always #25 aclk = ~aclk;
    lair_regs dut_u (.*);
    lair_src_model src_u (.*);
    task automatic close_out();
        $display("Counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic expire(input int k);
        if (k >= 60) begin
            n_mismatch++;
            close_out();
        end
    endtask
    function automatic logic [7:0] exp_byte(input lair_idx_t i);
        case (i)
            10'h062: return {4'h0, aud_e.word_len};
            10'h07B: return acr_e.stamp[19:12];
            10'h07C: return acr_e.stamp[11:4];
            10'h07D: return {acr_e.stamp[3:0], acr_e.divider[19:16]};
            10'h07E: return acr_e.divider[15:8];
            10'h07F: return acr_e.divider[7:0];
            10'h080: return avi_e.version;
            10'h081: return {1'b0, avi_e.enc, avi_e.afi, avi_e.bar, avi_e.scan};
            10'h082: return {avi_e.col, 6'h00};
            default: return 8'h00;
        endcase
    endfunction
    task automatic wr(input logic [11:0] a, input int st, input logic [1:0] er);
        int k;
        k = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= $urandom;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (k == st) s_axi_bready <= 1'b1;
            k++;
        end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) && k < 60);
        s_axi_bready <= 1'b0;
        check({30'h0, s_axi_bresp}, {30'h0, er});
        expire(k);
    endtask
    task automatic rd(input logic [11:0] a, input int st);
        int k;
        k = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (k == st) s_axi_rready <= 1'b1;
            k++;
        end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) && k < 60);
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        expire(k);
    endtask
    task automatic rd_all(input int st);
        foreach (idx_tab[j]) begin
            rd({idx_tab[j], 2'b00}, st);
            check(rd_d, {24'h000000, exp_byte(idx_tab[j])});
            check({30'h0, rd_r}, {30'h0, `LAIR_RESP_OKAY});
        end
    endtask
    task automatic send(input int i);
        acr_e = {1'b1, 20'($urandom), 20'($urandom)};
        avi_e = {1'b1, 8'($urandom), 2'(i % 3), 1'(i), 2'(i % 4), 2'((i + 1) % 3),
            2'((i + 2) % 3)};
        aud_e = {1'b1, 4'($urandom)};
        acr_cmd <= acr_e;
        avi_cmd <= avi_e;
        aud_cmd <= aud_e;
        @(posedge aclk);
        acr_cmd.valid <= 1'b0;
        avi_cmd.valid <= 1'b0;
        aud_cmd.valid <= 1'b0;
        @(posedge aclk);
    endtask
    initial begin
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        {acr_cmd, avi_cmd, aud_cmd, acr_e, avi_e, aud_e} = '0;
        void'($urandom(97635));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_all(0);
        $display("Test reset values done");
        for (int i = 0; i < 12; i++) begin
            send(i);
            rd_all(i % 3);
        end
        $display("Test packet fields done");
        foreach (idx_tab[j]) wr({idx_tab[j], 2'b00}, j % 3, `LAIR_RESP_OKAY);
        rd_all(1);
        $display("Test writes ignored done");
        wr(12'h000, 0, `LAIR_RESP_SLVERR);
        rd(12'h20C, 2);
        check(rd_d, 32'h00000000);
        check({30'h0, rd_r}, {30'h0, `LAIR_RESP_SLVERR});
        rd(12'h207, 0);
        check(rd_d, {24'h000000, exp_byte(10'h081)});
        $display("Test unmapped done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        {acr_e, avi_e, aud_e} = '0;
        @(posedge aclk);
        rd_all(0);
        $display("Test second reset done");
        close_out();
    end
endmodule

// ---- hdl/lair_consts.svh ----
// Register indices, field values and bus codes for the link status register bank
`ifndef LAIR_CONSTS_SVH
`define LAIR_CONSTS_SVH

// Register indices; the byte address is four times the index
`define LAIR_IDX_WORD_LEN 10'h062
`define LAIR_IDX_TS_HIGH 10'h07B
`define LAIR_IDX_TS_MID 10'h07C
`define LAIR_IDX_TS_LOW_DIV_HIGH 10'h07D
`define LAIR_IDX_DIV_MID 10'h07E
`define LAIR_IDX_DIV_LOW 10'h07F
`define LAIR_IDX_VIF_VERSION 10'h080
`define LAIR_IDX_VIF_FLAGS 10'h081
`define LAIR_IDX_VIF_COLOUR 10'h082

// Byte address bits that carry the index
`define LAIR_IDX_MSB 11
`define LAIR_IDX_LSB 2

// Field positions in the format flags register
`define LAIR_FLG_ENC_LSB 5
`define LAIR_FLG_AFI_BIT 4
`define LAIR_FLG_BAR_LSB 2
`define LAIR_FLG_SCAN_LSB 0
// Field position of colorimetry in the colour register
`define LAIR_COL_LSB 6

// Status reset value, none being printed
`define LAIR_STAT_RST 8'h00

// Bus response codes
`define LAIR_RESP_OKAY 2'h0
`define LAIR_RESP_SLVERR 2'h2

`endif

// ---- hdl/lair_pkg.sv ----
// Types and shared decode for the link status register bank
`include "lair_consts.svh"

package lair_pkg;

    typedef logic [9:0] lair_idx_t;

    // Pixel encoding codes
    typedef enum logic [1:0] {
        LAIR_ENC_RGB = 2'h0,
        LAIR_ENC_YCC422 = 2'h1,
        LAIR_ENC_YCC444 = 2'h2
    } lair_enc_t;

    // Bar information codes
    typedef enum logic [1:0] {
        LAIR_BAR_NONE = 2'h0,
        LAIR_BAR_HORIZ = 2'h1,
        LAIR_BAR_VERT = 2'h2,
        LAIR_BAR_BOTH = 2'h3
    } lair_bar_t;

    // Scan information codes
    typedef enum logic [1:0] {
        LAIR_SCAN_NONE = 2'h0,
        LAIR_SCAN_OVER = 2'h1,
        LAIR_SCAN_UNDER = 2'h2
    } lair_scan_t;

    // Colorimetry codes
    typedef enum logic [1:0] {
        LAIR_COL_NONE = 2'h0,
        LAIR_COL_601 = 2'h1,
        LAIR_COL_709 = 2'h2
    } lair_col_t;

    // Audio clock regeneration packet contents
    typedef struct packed {
        logic valid;
        logic [19:0] stamp;
        logic [19:0] divider;
    } lair_acr_t;

    // Auxiliary video information frame contents
    typedef struct packed {
        logic valid;
        logic [7:0] version;
        logic [1:0] enc;
        logic afi;
        logic [1:0] bar;
        logic [1:0] scan;
        logic [1:0] col;
    } lair_avi_t;

    // Audio channel status contents
    typedef struct packed {
        logic valid;
        logic [3:0] word_len;
    } lair_aud_t;

    // Captured status fields
    typedef struct packed {
        logic [3:0] word_len;
        logic [19:0] stamp;
        logic [19:0] divider;
        logic [7:0] version;
        logic [1:0] enc;
        logic afi;
        logic [1:0] bar;
        logic [1:0] scan;
        logic [1:0] col;
    } lair_stat_t;

    typedef enum logic [1:0] {
        LAIR_W_COLLECT = 2'b01,
        LAIR_W_RESP = 2'b10
    } lair_wst_t;

    typedef enum logic [2:0] {
        LAIR_R_IDLE = 3'b001,
        LAIR_R_FETCH = 3'b010,
        LAIR_R_RESP = 3'b100
    } lair_rst_t;

    // State of the register bank, apart from the read byte held in lair_rdmux
    typedef struct packed {
        lair_wst_t wst;
        lair_rst_t rst;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        lair_idx_t aw_idx;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        lair_idx_t ar_idx;
        logic rvalid;
        logic [1:0] rresp;
        lair_stat_t stat;
    } lair_state_t;

    localparam lair_state_t LAIR_STATE_RST = '{
        wst: LAIR_W_COLLECT,
        rst: LAIR_R_IDLE,
        awready: 1'b1,
        wready: 1'b1,
        arready: 1'b1,
        default: '0
    };

    // True for an index that holds a register
    function automatic logic lair_idx_mapped(input lair_idx_t idx);
        case (idx)
            `LAIR_IDX_WORD_LEN,
            `LAIR_IDX_TS_HIGH,
            `LAIR_IDX_TS_MID,
            `LAIR_IDX_TS_LOW_DIV_HIGH,
            `LAIR_IDX_DIV_MID,
            `LAIR_IDX_DIV_LOW,
            `LAIR_IDX_VIF_VERSION,
            `LAIR_IDX_VIF_FLAGS,
            `LAIR_IDX_VIF_COLOUR: lair_idx_mapped = 1'b1;
            default: lair_idx_mapped = 1'b0;
        endcase
    endfunction

endpackage

// ---- hdl/lair_rdmux.sv ----
// Registered read-data selector over the captured status fields
`timescale 1ns/10ps
`include "lair_consts.svh"

module lair_rdmux
    import lair_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Selection
    input wire logic load,
    input wire lair_idx_t idx,
    input wire lair_stat_t stat,
    // Registered byte
    output logic [7:0] data_q
);

    logic [7:0] data_d;

    always_comb begin
        data_d = `LAIR_STAT_RST;
        case (idx)
            `LAIR_IDX_WORD_LEN: data_d = {4'h0, stat.word_len};
            `LAIR_IDX_TS_HIGH: data_d = stat.stamp[19:12];
            `LAIR_IDX_TS_MID: data_d = stat.stamp[11:4];
            `LAIR_IDX_TS_LOW_DIV_HIGH: data_d = {stat.stamp[3:0], stat.divider[19:16]};
            `LAIR_IDX_DIV_MID: data_d = stat.divider[15:8];
            `LAIR_IDX_DIV_LOW: data_d = stat.divider[7:0];
            `LAIR_IDX_VIF_VERSION: data_d = stat.version;
            `LAIR_IDX_VIF_FLAGS: begin
                data_d[`LAIR_FLG_ENC_LSB+:2] = stat.enc;
                data_d[`LAIR_FLG_AFI_BIT] = stat.afi;
                data_d[`LAIR_FLG_BAR_LSB+:2] = stat.bar;
                data_d[`LAIR_FLG_SCAN_LSB+:2] = stat.scan;
            end
            `LAIR_IDX_VIF_COLOUR: data_d[`LAIR_COL_LSB+:2] = stat.col;
            default: data_d = `LAIR_STAT_RST;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_q <= `LAIR_STAT_RST;
        end else if (load) begin
            data_q <= data_d;
        end
    end

endmodule

// ---- hdl/lair_regs.sv ----
// Read-only link audio and video information status registers on AXI4-Lite
`timescale 1ns/10ps
`include "lair_consts.svh"

module lair_regs
    import lair_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address channel
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Decoded packet contents from the receiver
    input wire lair_acr_t acr_in,
    input wire lair_avi_t avi_in,
    input wire lair_aud_t aud_in
);

    lair_state_t q;
    lair_state_t d;
    logic [7:0] rd_byte_q;

    // Byte for the pending read, frozen once loaded
    lair_rdmux u_rdmux (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(q.rst == LAIR_R_FETCH),
        .idx(q.ar_idx),
        .stat(q.stat),
        .data_q(rd_byte_q)
    );

    always_comb begin
        d = q;

        // Write side accepts address and data in either order
        case (q.wst)
            LAIR_W_COLLECT: begin
                if (s_axi_awvalid && q.awready) begin
                    d.aw_idx = s_axi_awaddr[`LAIR_IDX_MSB:`LAIR_IDX_LSB];
                    d.aw_got = 1'b1;
                    d.awready = 1'b0;
                end
                if (s_axi_wvalid && q.wready) begin
                    d.w_got = 1'b1;
                    d.wready = 1'b0;
                end
                // Data are dropped; mapped targets answer OKAY
                if (d.aw_got && d.w_got) begin
                    d.wst = LAIR_W_RESP;
                    d.bvalid = 1'b1;
                    d.bresp = lair_idx_mapped(d.aw_idx) ? `LAIR_RESP_OKAY
                                                        : `LAIR_RESP_SLVERR;
                end
            end
            LAIR_W_RESP: begin
                if (s_axi_bready) begin
                    d.wst = LAIR_W_COLLECT;
                    d.bvalid = 1'b0;
                    d.aw_got = 1'b0;
                    d.w_got = 1'b0;
                    d.awready = 1'b1;
                    d.wready = 1'b1;
                end
            end
            default: begin
                d.wst = LAIR_W_COLLECT;
                d.bvalid = 1'b0;
                d.aw_got = 1'b0;
                d.w_got = 1'b0;
                d.awready = 1'b1;
                d.wready = 1'b1;
            end
        endcase

        // Read side: take address, load byte, answer
        case (q.rst)
            LAIR_R_IDLE: begin
                if (s_axi_arvalid) begin
                    d.rst = LAIR_R_FETCH;
                    d.arready = 1'b0;
                    d.ar_idx = s_axi_araddr[`LAIR_IDX_MSB:`LAIR_IDX_LSB];
                end
            end
            LAIR_R_FETCH: begin
                d.rst = LAIR_R_RESP;
                d.rvalid = 1'b1;
                d.rresp = lair_idx_mapped(q.ar_idx) ? `LAIR_RESP_OKAY : `LAIR_RESP_SLVERR;
            end
            LAIR_R_RESP: begin
                if (s_axi_rready) begin
                    d.rst = LAIR_R_IDLE;
                    d.rvalid = 1'b0;
                    d.arready = 1'b1;
                end
            end
            default: begin
                d.rst = LAIR_R_IDLE;
                d.rvalid = 1'b0;
                d.arready = 1'b1;
            end
        endcase

        // Status follows received packets alone
        if (acr_in.valid) begin
            d.stat.stamp = acr_in.stamp;
            d.stat.divider = acr_in.divider;
        end
        if (avi_in.valid) begin
            d.stat.version = avi_in.version;
            d.stat.enc = avi_in.enc;
            d.stat.afi = avi_in.afi;
            d.stat.bar = avi_in.bar;
            d.stat.scan = avi_in.scan;
            d.stat.col = avi_in.col;
        end
        if (aud_in.valid) begin
            d.stat.word_len = aud_in.word_len;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= LAIR_STATE_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state flops and the lair_rdmux byte flop
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rdata = {24'h000000, rd_byte_q};

endmodule
